/* src/scpi_pkg.sv */
// Shared constants, command tree table and carrier types of the parser.
// Assumes one clock domain; every user includes nothing and writes
// scpi_pkg::name in full.
package scpi_pkg;
    // ------------------------------------------------------------
    // Characters and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_SEMI = 8'h3b;
    localparam logic [7:0] CH_QUERY = 8'h3f;
    localparam logic [7:0] CASE_OFS = 8'h20;
    localparam int HDR_CH = 12;
    localparam int PAR_CH = 8;
    localparam int CODE_CH = 3;
    localparam int FIFO_DEPTH = 4;
    localparam int N_NODES = 11;
    localparam logic [3:0] ROOT = 4'h0;
    localparam logic [3:0] SRC_NODE = 4'h1;

    // ------------------------------------------------------------
    // Command tree: parent, implied default child, long and short
    // ------------------------------------------------------------
    localparam logic [3:0] TREE_PAR [1:N_NODES] = '{4'h0, 4'h1, 4'h2,
        4'h2, 4'h1, 4'h1, 4'h0, 4'h7, 4'h0, 4'h9, 4'ha};
    localparam logic [3:0] TREE_DEF [1:N_NODES] = '{4'h0, 4'h3, 4'h0,
        4'h0, 4'h0, 4'h0, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0};
    localparam logic [95:0] TREE_LONG [1:N_NODES] = '{96'("SOURCE"),
        96'("VOLTAGE"), 96'("LEVEL"), 96'("RANGE"), 96'("FREQUENCY"),
        96'("CURRENT"), 96'("OUTPUT"), 96'("STATE"), 96'("STATUS"),
        96'("OPERATION"), 96'("CONDITION")};
    localparam logic [95:0] TREE_SHORT [1:N_NODES] = '{96'("SOUR"),
        96'("VOLT"), 96'("LEV"), 96'("RANG"), 96'("FREQ"), 96'("CURR"),
        96'("OUTP"), 96'("STAT"), 96'("STAT"), 96'("OPER"), 96'("COND")};

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic eoi;
        logic [7:0] data;
    } scpi_rx_s;

    typedef struct packed {
        logic [3:0] node;
        logic query;
        logic common;
        logic [23:0] code;
        logic [63:0] param;
        logic [3:0] plen;
    } scpi_cmd_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR = 3'b001,
        ST_PARAM = 3'b011,
        ST_COMMON = 3'b010,
        ST_SKIP = 3'b110
    } scpi_state_e;
endpackage : scpi_pkg

/* src/scpi_parser.sv */
// Program message parser with its input FIFO.
// Assumes bytes, device clear, command and response handshakes all come
// from logic on sys_clk; the transport layers sit outside.
// How it works
// - Root path on reset, clear, terminator, root colon.
// - Each colon-joined header steps one level down.
// - After a leaf, keep its parent as context.
// - Omitted optional header is implied; context stays above.
// - Source subsystems accepted directly at root level.
// - Common command: asterisk, three letters, query/parameter.
// - Common commands leave the tree position alone.
// - No search of other tree levels.
// - Responses sent only for received queries.
// - New message over unread results: error, discard.
// - Long or short header spelling both match.
// - Header matching ignores letter case.
// - Unit is header, optional space and parameter.
// - Semicolon separates units; next uses retained level.
// - Trailing question mark makes the unit a query.
// - Input buffered through a 4-byte FIFO; rx_ready drops when it is full.
// - Line feed or end flag terminates message.
// - Leading colon of a unit means root.
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------
module scpi_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Fill side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic next_in_ready;
    logic do_wr, do_rd;

    // Pointer and count update; ready is registered from the new count.
    always_comb begin
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        next_wp = do_wr ? AW'((wp + 1'b1) % DEPTH) : wp;
        next_rp = do_rd ? AW'((rp + 1'b1) % DEPTH) : rp;
        next_cnt = cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        next_in_ready = (next_cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            in_ready <= 1'b1;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            in_ready <= next_in_ready;
        end
    end

    // Storage has no reset; only written words are ever read.
    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wp] <= in_data;
        end
    end

    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
endmodule : scpi_fifo

// ----------------------------------------------------------------
// Parser top
// ----------------------------------------------------------------
module scpi_parser (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Incoming program bytes.
    input wire logic rx_valid,
    input wire scpi_pkg::scpi_rx_s rx,
    output logic rx_ready,
    // Device clear.
    input wire logic dev_clr,
    // Parsed commands.
    output logic cmd_valid,
    output scpi_pkg::scpi_cmd_s cmd,
    input wire logic cmd_ready,
    output logic cmd_err,
    // Response bytes from the application.
    input wire logic resp_valid,
    input wire logic [7:0] resp_data,
    input wire logic resp_last,
    output logic resp_ready,
    // Response bytes to the controller.
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic query_err
);
    scpi_pkg::scpi_rx_s fo;
    logic fo_valid, take;
    scpi_pkg::scpi_state_e state, next_state;
    logic [3:0] ctx, path, node, hit_id, fin_node;
    logic [3:0] next_ctx, next_path, next_node, hlen, next_hlen;
    logic [3:0] plen, next_plen, fin_plen;
    logic [1:0] ccnt, next_ccnt;
    logic [95:0] hdr, next_hdr, hdr_in;
    logic [63:0] par, next_par, fin_par;
    logic [23:0] code, next_code, fin_code;
    logic query, next_query, ucom, next_ucom, msg_start, next_msg_start;
    logic fin_query;
    logic pend, next_pend, next_cmd_valid, next_cmd_err, next_query_err;
    logic next_tx_valid, next_resp_ready, take_resp;
    logic [7:0] next_tx_data, u;
    scpi_pkg::scpi_cmd_s next_cmd;
    logic hit, fin, err, is_lf, term, sep, is_let, is_alnum;

    // Input buffer takes up to FIFO_DEPTH bytes while the parser is stalled, then holds off the link.
    scpi_fifo #(.WIDTH(9), .DEPTH(scpi_pkg::FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(rx_valid),
        .in_data(rx),
        .in_ready(rx_ready),
        .out_valid(fo_valid),
        .out_data(fo),
        .out_ready(take)
    );

    // The parser holds off while a finished command waits for its sink.
    assign take = fo_valid && !(cmd_valid && !cmd_ready);

    // Byte classes; letters folded to upper case before any compare.
    always_comb begin
        is_let = (fo.data >= 8'h61 && fo.data <= 8'h7a);
        u = is_let ? fo.data - scpi_pkg::CASE_OFS : fo.data;
        is_let = is_let || (fo.data >= 8'h41 && fo.data <= 8'h5a);
        is_alnum = is_let || (fo.data >= 8'h30 && fo.data <= 8'h39);
        is_lf = (fo.data == scpi_pkg::CH_LF);
        term = is_lf || fo.eoi;
        sep = (fo.data == scpi_pkg::CH_SEMI);
        hdr_in = is_alnum ? {hdr[87:0], u} : hdr;
    end

    // Header lookup among children of the current path, plus source children at root.
    always_comb begin
        hit = 1'b0;
        hit_id = scpi_pkg::ROOT;
        for (int i = 1; i <= scpi_pkg::N_NODES; i++) begin
            if ((scpi_pkg::TREE_PAR[i] == path ||
                 (path == scpi_pkg::ROOT &&
                  scpi_pkg::TREE_PAR[i] == scpi_pkg::SRC_NODE)) &&
                (hdr_in == scpi_pkg::TREE_LONG[i] ||
                 hdr_in == scpi_pkg::TREE_SHORT[i])) begin
                hit = 1'b1;
                hit_id = 4'(i);
            end
        end
    end

    // Parser next state. Quoted strings holding a semicolon are not
    // protected; the parameter field is short by design.
    always_comb begin
        next_state = state;
        next_ctx = ctx;
        next_path = path;
        next_node = node;
        next_hdr = hdr;
        next_hlen = hlen;
        next_par = par;
        next_plen = plen;
        next_code = code;
        next_ccnt = ccnt;
        next_query = query;
        next_ucom = ucom;
        next_msg_start = msg_start;
        fin = 1'b0;
        fin_node = node;
        // The byte that ends a unit may itself be content when it carries
        // the end flag, so the finished fields can differ from the stored.
        fin_par = par;
        fin_plen = plen;
        fin_code = code;
        fin_query = query;
        err = 1'b0;
        if (take) begin
            case (state)
                scpi_pkg::ST_IDLE: begin
                    if (term || sep || fo.data == scpi_pkg::CH_SP) begin
                        next_state = scpi_pkg::ST_IDLE;
                    end else if (fo.data == scpi_pkg::CH_STAR) begin
                        next_state = scpi_pkg::ST_COMMON;
                        next_ucom = 1'b1;
                    end else if (fo.data == scpi_pkg::CH_COLON) begin
                        next_ctx = scpi_pkg::ROOT;
                    end else if (is_let) begin
                        next_state = scpi_pkg::ST_HDR;
                        next_path = ctx;
                        next_hdr = hdr_in;
                        next_hlen = 4'h1;
                    end else begin
                        err = 1'b1;
                    end
                end
                scpi_pkg::ST_HDR: begin
                    if (is_alnum && !fo.eoi) begin
                        next_hdr = hdr_in;
                        next_hlen = hlen + 4'h1;
                        err = (hlen == 4'(scpi_pkg::HDR_CH));
                    end else if (!hit) begin
                        err = 1'b1;
                    end else if (sep || term) begin
                        fin = 1'b1;
                        fin_node = hit_id;
                        fin_query = (fo.data == scpi_pkg::CH_QUERY);
                    end else if (fo.data == scpi_pkg::CH_COLON) begin
                        next_path = hit_id;
                        next_hdr = '0;
                        next_hlen = 4'h0;
                    end else if (fo.data == scpi_pkg::CH_QUERY) begin
                        next_node = hit_id;
                        next_query = 1'b1;
                        next_state = scpi_pkg::ST_PARAM;
                    end else if (fo.data == scpi_pkg::CH_SP) begin
                        next_node = hit_id;
                        next_state = scpi_pkg::ST_PARAM;
                    end else begin
                        err = 1'b1;
                    end
                end
                scpi_pkg::ST_PARAM: begin
                    if (!is_lf && !sep &&
                        !(fo.data == scpi_pkg::CH_SP && plen == 4'h0)) begin
                        next_par = {par[55:0], fo.data};
                        next_plen = plen + 4'h1;
                        err = (plen == 4'(scpi_pkg::PAR_CH));
                        fin_par = next_par;
                        fin_plen = next_plen;
                    end
                    fin = (sep || term) && !err;
                end
                scpi_pkg::ST_COMMON: begin
                    if (is_let && ccnt != 2'(scpi_pkg::CODE_CH)) begin
                        next_code = {code[15:0], u};
                        next_ccnt = ccnt + 2'h1;
                        fin_code = next_code;
                        // An end flag on the third letter closes the unit.
                        fin = fo.eoi && ccnt == 2'(scpi_pkg::CODE_CH - 1);
                        err = fo.eoi && !fin;
                    end else if (sep || term) begin
                        fin = (ccnt == 2'(scpi_pkg::CODE_CH)) && !is_let;
                        fin_query = query || fo.data == scpi_pkg::CH_QUERY;
                        err = !fin;
                    end else if (ccnt != 2'(scpi_pkg::CODE_CH)) begin
                        err = 1'b1;
                    end else if (fo.data == scpi_pkg::CH_QUERY) begin
                        next_query = 1'b1;
                    end else if (fo.data == scpi_pkg::CH_SP) begin
                        next_state = scpi_pkg::ST_PARAM;
                    end else begin
                        err = 1'b1;
                    end
                end
                scpi_pkg::ST_SKIP: begin
                    next_state = scpi_pkg::ST_SKIP;
                end
                default: begin
                    next_state = scpi_pkg::ST_IDLE;
                end
            endcase
            if (err) begin
                next_state = scpi_pkg::ST_SKIP;
            end
            if (fin && !ucom) begin
                next_ctx = scpi_pkg::TREE_PAR[fin_node];
            end
            if (sep || term) begin
                next_state = scpi_pkg::ST_IDLE;
                next_hdr = '0;
                next_hlen = 4'h0;
                next_par = '0;
                next_plen = 4'h0;
                next_code = '0;
                next_ccnt = 2'h0;
                next_query = 1'b0;
                next_ucom = 1'b0;
            end
            if (term) begin
                next_ctx = scpi_pkg::ROOT;
            end
            next_msg_start = term;
        end
        if (dev_clr) begin
            next_state = scpi_pkg::ST_IDLE;
            next_ctx = scpi_pkg::ROOT;
            next_msg_start = 1'b1;
        end
    end

    // Command output, query bookkeeping and response gate.
    always_comb begin
        next_cmd = cmd;
        next_cmd_valid = cmd_valid && !cmd_ready;
        next_cmd_err = err;
        next_query_err = 1'b0;
        next_pend = pend;
        next_tx_valid = tx_valid && !tx_ready;
        next_tx_data = tx_data;
        take_resp = resp_valid && resp_ready;
        if (take_resp && pend) begin
            next_tx_valid = 1'b1;
            next_tx_data = resp_data;
            next_pend = !resp_last;
        end
        if ((take && msg_start && !is_lf && (pend || tx_valid)) ||
            dev_clr) begin
            next_query_err = !dev_clr;
            next_pend = 1'b0;
            next_tx_valid = 1'b0;
        end
        if (fin) begin
            next_cmd_valid = 1'b1;
            // A common command names no tree node; root keeps the table
            // lookup inside its index range.
            next_cmd.node = ucom ? scpi_pkg::ROOT :
                (scpi_pkg::TREE_DEF[fin_node] != 4'h0) ?
                scpi_pkg::TREE_DEF[fin_node] : fin_node;
            next_cmd.query = fin_query;
            next_cmd.common = ucom;
            next_cmd.code = fin_code;
            next_cmd.param = fin_par;
            next_cmd.plen = fin_plen;
            if (fin_query) begin
                next_pend = 1'b1;
            end
        end
        // Unsolicited data is sunk, never sent, so the source cannot hang.
        next_resp_ready = !next_pend || (!next_tx_valid && !take_resp);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= scpi_pkg::ST_IDLE;
            ctx <= scpi_pkg::ROOT;
            path <= scpi_pkg::ROOT;
            node <= scpi_pkg::ROOT;
            hdr <= '0;
            hlen <= '0;
            par <= '0;
            plen <= '0;
            code <= '0;
            ccnt <= '0;
            query <= 1'b0;
            ucom <= 1'b0;
            msg_start <= 1'b1;
            pend <= 1'b0;
            cmd <= '0;
            cmd_valid <= 1'b0;
            cmd_err <= 1'b0;
            query_err <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= '0;
            resp_ready <= 1'b1;
        end else begin
            state <= next_state;
            ctx <= next_ctx;
            path <= next_path;
            node <= next_node;
            hdr <= next_hdr;
            hlen <= next_hlen;
            par <= next_par;
            plen <= next_plen;
            code <= next_code;
            ccnt <= next_ccnt;
            query <= next_query;
            ucom <= next_ucom;
            msg_start <= next_msg_start;
            pend <= next_pend;
            cmd <= next_cmd;
            cmd_valid <= next_cmd_valid;
            cmd_err <= next_cmd_err;
            query_err <= next_query_err;
            tx_valid <= next_tx_valid;
            tx_data <= next_tx_data;
            resp_ready <= next_resp_ready;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_query_done;
        fin && fin_query;
    endsequence

    term_root_a: assert property (take && term |=> ctx == 4'h0)
        else $error("Context not at root after terminator.");
    clear_root_a: assert property (dev_clr |=>
        ctx == 4'h0 && state == scpi_pkg::ST_IDLE)
        else $error("Device clear did not return to root.");
    common_keep_a: assert property (fin && ucom && !term && !dev_clr
        |=> ctx == $past(ctx))
        else $error("Common command moved the tree position.");
    sibling_ctx_a: assert property (fin && !ucom && !term && !dev_clr
        |=> ctx == scpi_pkg::TREE_PAR[$past(fin_node)])
        else $error("Context after leaf is not its parent.");
    tx_solicit_a: assert property ($rose(tx_valid) |-> $past(pend))
        else $error("Response sent without a pending query.");
    qerr_drop_a: assert property (query_err |-> !pend && !tx_valid)
        else $error("Unread response kept after query error.");
    query_pend_a: assert property (s_query_done |=>
        pend && cmd_valid && cmd.query)
        else $error("Query did not raise a pending response.");
    err_skip_a: assert property (take && err && !sep && !term && !dev_clr
        |=> cmd_err && state == scpi_pkg::ST_SKIP)
        else $error("Malformed unit not discarded.");
    cmd_hold_a: assert property (cmd_valid && !cmd_ready |=>
        cmd_valid && $stable(cmd))
        else $error("Command dropped while sink stalled.");
endmodule : scpi_parser

/* tb/scpi_ctrl_model.sv */
// Behavioural remote controller: sends program bytes, reads responses.
// Assumes the bench queues messages through the send task.
`timescale 1ns/1ns
module scpi_ctrl_model (
    // Clock.
    input wire logic sys_clk,
    // Program bytes out.
    output logic rx_valid,
    output scpi_pkg::scpi_rx_s rx,
    input wire logic rx_ready,
    // Response bytes in.
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    scpi_pkg::scpi_rx_s q[$];
    logic [7:0] got[$];
    logic slow = 1'b0;
    logic took;

    // Queue a message; with eoi_end set, the end flag on the last byte ends it.
    task automatic send(input string s, input logic eoi_end);
        for (int i = 0; i < s.len(); i++) begin
            q.push_back('{eoi_end && i == s.len() - 1, s[i]});
        end
    endtask : send

    // Each byte stands until taken; idle lines carry the inverse so a
    // stale value is never mistaken for fresh data.
    initial begin
        rx_valid = 1'b0;
        rx = '0;
        tx_ready = 1'b1;
        forever begin
            @(posedge sys_clk);
            took = rx_valid && rx_ready;
            if (tx_valid && tx_ready) got.push_back(tx_data);
            #1;
            tx_ready = !slow;
            if (took || !rx_valid) begin
                if (q.size() > 0) begin
                    rx_valid = 1'b1;
                    rx = q.pop_front();
                end else begin
                    rx_valid = 1'b0;
                    rx = ~rx;
                end
            end
        end
    end
endmodule : scpi_ctrl_model

/* tb/tb_scpi_parser.sv */
// Self-checking bench of the program message parser.
// Assumes the controller model drives the byte side.
`timescale 1ns/1ns
module tb_scpi_parser;
    logic sys_clk, rst, rx_valid, rx_ready, dev_clr, cmd_valid, cmd_ready;
    logic cmd_err, resp_valid, resp_last, resp_ready, tx_valid, tx_ready;
    logic query_err, saw_full;
    logic [7:0] resp_data, tx_data;
    scpi_pkg::scpi_rx_s rx;
    scpi_pkg::scpi_cmd_s cmd;
    scpi_pkg::scpi_cmd_s cq[$];
    int bad_count = 0;
    int n_checks = 0;
    int errs, qerrs;

    // ------------------------------------------------------------
    // Instances and monitor
    // ------------------------------------------------------------
    scpi_parser u_scpi_parser (.sys_clk(sys_clk), .rst(rst),
        .rx_valid(rx_valid), .rx(rx), .rx_ready(rx_ready),
        .dev_clr(dev_clr), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .cmd_err(cmd_err), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_last(resp_last),
        .resp_ready(resp_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .query_err(query_err));
    scpi_ctrl_model u_scpi_ctrl_model (.sys_clk(sys_clk),
        .rx_valid(rx_valid), .rx(rx), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    // Clock at 125 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Collect commands and count error pulses, which stand one cycle.
    always @(posedge sys_clk) begin
        if (cmd_valid && cmd_ready) cq.push_back(cmd);
        if (cmd_err) errs++;
        if (query_err) qerrs++;
        if (!rx_ready) saw_full = 1'b1;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask : cyc

    // Send a message and wait, bounded, for n commands.
    task automatic run(input string s, input logic e, input int n);
        int k;
        k = 0;
        cq.delete();
        errs = 0;
        qerrs = 0;
        u_scpi_ctrl_model.send(s, e);
        while ((rx_valid || u_scpi_ctrl_model.q.size() > 0 ||
                cq.size() < n) && k < 400) begin
            cyc(1);
            k++;
        end
        cyc(8);
        chk(cq.size(), n);
    endtask : run

    task automatic ec(input int i, input logic [3:0] nd, input logic qy,
                      input logic [63:0] p, input logic [3:0] pl);
        chk({cq[i].node, cq[i].query, cq[i].common, cq[i].param,
             cq[i].plen}, {nd, qy, 1'b0, p, pl});
    endtask : ec

    // One response byte, held until taken.
    task automatic rsp(input logic [7:0] d, input logic l);
        int k;
        k = 0;
        resp_valid = 1'b1;
        resp_data = d;
        resp_last = l;
        do begin
            @(posedge sys_clk);
            k++;
        end while (!resp_ready && k < 50);
        #1;
        resp_valid = 1'b0;
        resp_data = ~d;
    endtask : rsp

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_path;
        int k;
        cmd_ready = 1'b0;
        saw_full = 1'b0;
        u_scpi_ctrl_model.send("SOUR:VOLT:RANG 156;LEV 115\n", 1'b0);
        for (k = 0; k < 100 && !saw_full; k++) cyc(1);
        cyc(3);
        cmd_ready = 1'b1;
        chk(saw_full, 1'b1);
        run("", 1'b0, 2);
        ec(0, 4'h4, 1'b0, "156", 4'h3);
        ec(1, 4'h3, 1'b0, "115", 4'h3);
        chk(errs, 0);
    endtask : t_path

    task automatic t_implied;
        run("volt 115;Freq 60\n", 1'b0, 2);
        ec(0, 4'h3, 1'b0, "115", 4'h3);
        ec(1, 4'h5, 1'b0, "60", 4'h2);
        run("VOLTAGE:LEVEL 7;RANGE 8\n", 1'b0, 2);
        ec(0, 4'h3, 1'b0, "7", 4'h1);
        ec(1, 4'h4, 1'b0, "8", 4'h1);
    endtask : t_implied

    task automatic t_root;
        run("VOLT:RANG 1;:FREQ 2\n", 1'b0, 2);
        ec(1, 4'h5, 1'b0, "2", 4'h1);
        run("OUTP ON;:STAT:OPER:COND?\n", 1'b0, 2);
        ec(0, 4'h8, 1'b0, "ON", 4'h2);
        ec(1, 4'hb, 1'b1, 64'h0, 4'h0);
    endtask : t_root

    task automatic t_common;
        run("VOLT:RANG 1;*idn?;LEV 2\n", 1'b0, 3);
        chk({cq[1].common, cq[1].query, cq[1].code}, {2'b11, "IDN"});
        ec(2, 4'h3, 1'b0, "2", 4'h1);
        run("*rst", 1'b1, 1);
        chk({cq[0].common, cq[0].code}, {1'b1, "RST"});
        run("VOLT?", 1'b1, 1);
        chk({cq[0].node, cq[0].query}, {4'h3, 1'b1});
    endtask : t_common

    task automatic t_errs;
        run("VOLT:LEV 1;COND 2\n", 1'b0, 1);
        chk(errs, 1);
        run("VOLT:RANG 5", 1'b1, 1);
        ec(0, 4'h4, 1'b0, "5", 4'h1);
        run("LEV 6\n", 1'b0, 0);
        chk(errs, 1);
        run("VOLT:RANG 1;", 1'b0, 1);
        dev_clr = 1'b1;
        cyc(1);
        dev_clr = 1'b0;
        run("LEV 2\n", 1'b0, 0);
        chk(errs, 1);
    endtask : t_errs

    task automatic t_query;
        rsp("7", 1'b1);
        cyc(4);
        chk(u_scpi_ctrl_model.got.size(), 0);
        run("VOLT?\n", 1'b0, 1);
        rsp("5", 1'b1);
        cyc(4);
        chk(u_scpi_ctrl_model.got[0], 8'h35);
        u_scpi_ctrl_model.slow = 1'b1;
        run("VOLT?\n", 1'b0, 1);
        rsp("9", 1'b1);
        cyc(2);
        chk(tx_valid, 1'b1);
        run("FREQ 1\n", 1'b0, 1);
        chk({qerrs[1:0], tx_valid}, 3'b010);
        u_scpi_ctrl_model.slow = 1'b0;
        cyc(3);
        chk(u_scpi_ctrl_model.got.size(), 1);
    endtask : t_query

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic summarize;
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // The tests take some 400 cycles; this limit of 25,000 cycles leaves wide room.
    initial begin
        #200000;
        bad_count++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        dev_clr = 1'b0;
        cmd_ready = 1'b1;
        resp_valid = 1'b0;
        resp_data = 8'h00;
        resp_last = 1'b0;
        cyc(3);
        rst = 1'b0;
        chk({rx_ready, cmd_valid, tx_valid, resp_ready, query_err},
            5'b10010);
        t_path();
        t_implied();
        t_root();
        t_common();
        t_errs();
        t_query();
        summarize();
    end
endmodule : tb_scpi_parser
